// [inc/lpc_pkg.sv]
// Package for the low power comparator control block: offsets, fields, types
package lpc_pkg;
   // Register byte offsets
   localparam logic [11:0] LPC_TASK_START_OFS  = 12'h000;
   localparam logic [11:0] LPC_TASK_STOP_OFS   = 12'h004;
   localparam logic [11:0] LPC_TASK_SAMPLE_OFS = 12'h008;
   localparam logic [11:0] LPC_EV_READY_OFS    = 12'h100;
   localparam logic [11:0] LPC_EV_DOWN_OFS     = 12'h104;
   localparam logic [11:0] LPC_EV_UP_OFS       = 12'h108;
   localparam logic [11:0] LPC_EV_CROSS_OFS    = 12'h10C;
   localparam logic [11:0] LPC_SHORTCUT_OFS    = 12'h200;
   localparam logic [11:0] LPC_INT_EN_OFS      = 12'h300;
   localparam logic [11:0] LPC_INT_SET_OFS     = 12'h304;
   localparam logic [11:0] LPC_INT_CLR_OFS     = 12'h308;
   localparam logic [11:0] LPC_RESULT_OFS      = 12'h400;
   localparam logic [11:0] LPC_ENABLE_OFS      = 12'h500;
   localparam logic [11:0] LPC_PIN_SEL_OFS     = 12'h504;
   localparam logic [11:0] LPC_REF_SEL_OFS     = 12'h508;
   localparam logic [11:0] LPC_EXT_REF_OFS     = 12'h50C;
   localparam logic [11:0] LPC_WAKE_CFG_OFS    = 12'h520;
   // Event bit positions (interrupt enable layout)
   localparam int LPC_EV_READY = 0;
   localparam int LPC_EV_DOWN  = 1;
   localparam int LPC_EV_UP    = 2;
   localparam int LPC_EV_CROSS = 3;
   // Shortcut bit positions
   localparam int LPC_SC_READY_SAMPLE = 0;
   localparam int LPC_SC_READY_STOP   = 1;
   localparam int LPC_SC_DOWN_STOP    = 2;
   localparam int LPC_SC_UP_STOP      = 3;
   localparam int LPC_SC_CROSS_STOP   = 4;
   // Reference select code for external reference
   localparam logic [2:0] LPC_REF_EXTERNAL = 3'h7;
   // Wake-detect codes
   localparam logic [1:0] LPC_WAKE_CROSS = 2'h0;
   localparam logic [1:0] LPC_WAKE_UP    = 2'h1;
   localparam logic [1:0] LPC_WAKE_DOWN  = 2'h2;
   // Reset values
   localparam logic [31:0] LPC_RESET_WORD = 32'h0000_0000;
   // Start-up time of the comparator, ns, and its cycle count at 20 MHz
   localparam int LPC_CLK_PERIOD_NS  = 50;
   localparam int LPC_STARTUP_NS     = 140000;
   localparam int LPC_STARTUP_CYCLES =
      (LPC_STARTUP_NS + LPC_CLK_PERIOD_NS - 1) / LPC_CLK_PERIOD_NS;
   // Analog control bundle to the comparator front end
   typedef struct packed {
      logic       power_on;
      logic [2:0] positive_input;
      logic [2:0] reference_select;
      logic       external_reference;
      logic [1:0] wake_detect_mode;
   } lpc_analog_t;
   // Run state
   typedef enum logic [2:0] {
      LPC_IDLE  = 3'b001,
      LPC_START = 3'b010,
      LPC_RUN   = 3'b100
   } lpc_state_t;
endpackage : lpc_pkg

// [verilog/lpc_ctrl.sv]
// Control and register logic of the low power comparator
//
// Summary of operation
// - The input-pin select code 0..7 routes one of eight analog inputs to the positive input.
// - The reference select picks supply eighths 1/8..7/8 for codes 0..6, or the external reference.
// - The external reference select picks the first pin on 0 and the second on 1, when external.
// - Wake-detect fires on any crossing for code 0, upward for 1, downward for 2.
// - The result bit reads 0 below and 1 above, captured when the sample task fires.
// - The enable bit turns the comparator off on 0 and on on 1, and resets to 0.
// - The interrupt enable holds ready, down, up and cross in bits 0 to 3.
// - Writing 1 to interrupt-set sets the enable bit; 0 leaves it; a read returns the enables.
// - With shortcut bit 3 set an upward event triggers the stop task.
// - With shortcut bit 4 set a crossing event triggers the stop task.
// - A rising crossing raises up and cross events; a falling one raises down and cross.
// - After the start task a fixed start-up time passes, then the ready event is raised.
`timescale 1ns/1ns
`default_nettype none
module lpc_ctrl
   import lpc_pkg::*;
#(
   parameter int STARTUP_CYCLES = LPC_STARTUP_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        comp_decision,
   output lpc_analog_t      analog_ctrl,
   output logic             wake_detect,
   output logic             irq
);
   //--------------------------------------------------------------
   // Bus slave
   //--------------------------------------------------------------
   logic        wr_pend_r;
   logic [11:0] wr_addr_r;
   logic        rd_pend_r;
   logic [11:0] rd_addr_r;
   logic        addr_ok;
   assign addr_ok = hsel && hready && htrans[1];

   // Capture address phase; write lands in data phase
   // A read address phase also brings one wait state, see the read data register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
         rd_addr_r <= 12'h000;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         rd_pend_r <= addr_ok && !hwrite;
         wr_addr_r <= haddr[11:0];
         rd_addr_r <= haddr[11:0];
      end
   end

   logic wr_start, wr_stop, wr_sample;
   assign wr_start  = wr_pend_r && wr_addr_r == LPC_TASK_START_OFS  && hwdata[0];
   assign wr_stop   = wr_pend_r && wr_addr_r == LPC_TASK_STOP_OFS   && hwdata[0];
   assign wr_sample = wr_pend_r && wr_addr_r == LPC_TASK_SAMPLE_OFS && hwdata[0];

   //--------------------------------------------------------------
   // Configuration registers
   //--------------------------------------------------------------
   logic [4:0] shortcut_r;
   logic [3:0] int_en_r;
   logic       enable_r;
   logic [2:0] pin_sel_r;
   logic [2:0] ref_sel_r;
   logic       ext_ref_r;
   logic [1:0] wake_cfg_r;

   // Plain read-write configuration
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shortcut_r <= LPC_RESET_WORD[4:0];
         enable_r   <= LPC_RESET_WORD[0];
         pin_sel_r  <= LPC_RESET_WORD[2:0];
         ref_sel_r  <= LPC_RESET_WORD[2:0];
         ext_ref_r  <= LPC_RESET_WORD[0];
         wake_cfg_r <= LPC_RESET_WORD[1:0];
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            LPC_SHORTCUT_OFS: shortcut_r <= hwdata[4:0];
            LPC_ENABLE_OFS:   enable_r   <= hwdata[0];
            LPC_PIN_SEL_OFS:  pin_sel_r  <= hwdata[2:0];
            LPC_REF_SEL_OFS:  ref_sel_r  <= hwdata[2:0];
            LPC_EXT_REF_OFS:  ext_ref_r  <= hwdata[0];
            LPC_WAKE_CFG_OFS: wake_cfg_r <= hwdata[1:0];
            default: ;
         endcase
      end
   end

   // Interrupt enable with set and clear aliases
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         int_en_r <= LPC_RESET_WORD[3:0];
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            LPC_INT_EN_OFS:  int_en_r <= hwdata[3:0];
            LPC_INT_SET_OFS: int_en_r <= int_en_r | hwdata[3:0];
            LPC_INT_CLR_OFS: int_en_r <= int_en_r & ~hwdata[3:0];
            default: ;
         endcase
      end
   end

   //--------------------------------------------------------------
   // Decision synchroniser and crossing detect
   //--------------------------------------------------------------
   logic sync1_r, sync2_r, prev_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
      end else begin
         sync1_r <= comp_decision;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   //--------------------------------------------------------------
   // Run state machine
   //--------------------------------------------------------------
   lpc_state_t state_r;
   logic [31:0] cnt_r;
   logic running;
   assign running = state_r == LPC_RUN;
   logic rise, fall;
   assign rise = running && sync2_r && !prev_r;
   assign fall = running && !sync2_r && prev_r;
   logic ev_ready;
   assign ev_ready = state_r == LPC_START && cnt_r == 32'(STARTUP_CYCLES - 1);
   logic stop_req;
   assign stop_req = wr_stop
      || (shortcut_r[LPC_SC_UP_STOP] && rise)
      || (shortcut_r[LPC_SC_CROSS_STOP] && (rise || fall))
      || (shortcut_r[LPC_SC_DOWN_STOP] && fall)
      || (shortcut_r[LPC_SC_READY_STOP] && ev_ready);

   // Start, start-up wait, run and stop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= LPC_IDLE;
         cnt_r   <= 32'h0000_0000;
      end else if (!enable_r || stop_req) begin
         state_r <= LPC_IDLE;
         cnt_r   <= 32'h0000_0000;
      end else begin
         case (state_r)
            LPC_IDLE: begin
               cnt_r <= 32'h0000_0000;
               if (wr_start) begin
                  state_r <= LPC_START;
               end
            end
            LPC_START: begin
               cnt_r <= cnt_r + 32'h0000_0001;
               if (ev_ready) begin
                  state_r <= LPC_RUN;
               end
            end
            LPC_RUN: cnt_r <= 32'h0000_0000;
            default: state_r <= LPC_IDLE;
         endcase
      end
   end

   //--------------------------------------------------------------
   // Result capture
   //--------------------------------------------------------------
   logic result_r;
   logic do_sample;
   assign do_sample = wr_sample || (shortcut_r[LPC_SC_READY_SAMPLE] && ev_ready);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         result_r <= 1'b0;
      end else if (do_sample) begin
         result_r <= sync2_r;
      end
   end

   //--------------------------------------------------------------
   // Latched events and interrupt
   //--------------------------------------------------------------
   logic [3:0] ev_r;
   logic [3:0] ev_set;
   logic [3:0] ev_clr;
   assign ev_set = {rise || fall, rise, fall, ev_ready};
   always_comb begin
      ev_clr = 4'h0;
      if (wr_pend_r && !hwdata[0]) begin
         case (wr_addr_r)
            LPC_EV_READY_OFS: ev_clr[LPC_EV_READY] = 1'b1;
            LPC_EV_DOWN_OFS:  ev_clr[LPC_EV_DOWN]  = 1'b1;
            LPC_EV_UP_OFS:    ev_clr[LPC_EV_UP]    = 1'b1;
            LPC_EV_CROSS_OFS: ev_clr[LPC_EV_CROSS] = 1'b1;
            default: ;
         endcase
      end
   end
   // Set wins over clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ev_r <= 4'h0;
      end else begin
         ev_r <= (ev_r & ~ev_clr) | ev_set;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((ev_r & ~ev_clr) | ev_set) & int_en_r);
      end
   end

   //--------------------------------------------------------------
   // Analog controls and wake detect
   //--------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         analog_ctrl <= '0;
         wake_detect <= 1'b0;
      end else begin
         analog_ctrl.power_on           <= enable_r;
         analog_ctrl.positive_input     <= pin_sel_r;
         analog_ctrl.reference_select   <= ref_sel_r;
         analog_ctrl.external_reference <= ext_ref_r && ref_sel_r == LPC_REF_EXTERNAL;
         analog_ctrl.wake_detect_mode   <= wake_cfg_r;
         case (wake_cfg_r)
            LPC_WAKE_CROSS: wake_detect <= rise || fall;
            LPC_WAKE_UP:    wake_detect <= rise;
            LPC_WAKE_DOWN:  wake_detect <= fall;
            default:        wake_detect <= 1'b0;
         endcase
      end
   end

   //--------------------------------------------------------------
   // Read data
   //--------------------------------------------------------------
   // Read mux, decoded from the address held since the address phase
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0000_0000;
      case (rd_addr_r)
         LPC_EV_READY_OFS: rd_word[0]   = ev_r[LPC_EV_READY];
         LPC_EV_DOWN_OFS:  rd_word[0]   = ev_r[LPC_EV_DOWN];
         LPC_EV_UP_OFS:    rd_word[0]   = ev_r[LPC_EV_UP];
         LPC_EV_CROSS_OFS: rd_word[0]   = ev_r[LPC_EV_CROSS];
         LPC_SHORTCUT_OFS: rd_word[4:0] = shortcut_r;
         LPC_INT_EN_OFS:   rd_word[3:0] = int_en_r;
         LPC_INT_SET_OFS:  rd_word[3:0] = int_en_r;
         LPC_INT_CLR_OFS:  rd_word[3:0] = int_en_r;
         LPC_RESULT_OFS:   rd_word[0]   = result_r;
         LPC_ENABLE_OFS:   rd_word[0]   = enable_r;
         LPC_PIN_SEL_OFS:  rd_word[2:0] = pin_sel_r;
         LPC_REF_SEL_OFS:  rd_word[2:0] = ref_sel_r;
         LPC_EXT_REF_OFS:  rd_word[0]   = ext_ref_r;
         LPC_WAKE_CFG_OFS: rd_word[1:0] = wake_cfg_r;
         default: ;
      endcase
   end
   // Reads take one wait state: the word is registered in the first data-phase cycle,
   // so a write that lands at the read's address edge is already visible
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hrdata    <= rd_pend_r ? rd_word : 32'h0000_0000;
         hreadyout <= !(addr_ok && !hwrite);             // Wait state for reads
         hresp     <= 1'b0;
      end
   end

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   sequence s_rise;
      running && sync2_r && !prev_r;
   endsequence
   up_cross_ev_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_rise |=> ev_r[LPC_EV_UP] && ev_r[LPC_EV_CROSS])
      else $error("upward crossing lost");
   down_ev_a: assert property (@(posedge clk) disable iff (!reset_n)
      fall |=> ev_r[LPC_EV_DOWN] && ev_r[LPC_EV_CROSS] && !$past(ev_set[LPC_EV_UP]))
      else $error("downward crossing lost");
   enable_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
      !enable_r |=> state_r == LPC_IDLE && !analog_ctrl.power_on)
      else $error("disabled comparator still active");
   int_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_pend_r && wr_addr_r == LPC_INT_SET_OFS |=> (int_en_r & $past(hwdata[3:0])) == $past(hwdata[3:0]))
      else $error("interrupt set failed");
   int_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_pend_r && wr_addr_r == LPC_INT_CLR_OFS |=> (int_en_r & $past(hwdata[3:0])) == 4'h0)
      else $error("interrupt clear failed");
   up_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
      shortcut_r[LPC_SC_UP_STOP] && rise |=> state_r == LPC_IDLE)
      else $error("upward shortcut missed stop");
   cross_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
      shortcut_r[LPC_SC_CROSS_STOP] && (rise || fall) |=> state_r == LPC_IDLE)
      else $error("crossing shortcut missed stop");
   sample_res_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_sample |=> result_r == $past(sync2_r))
      else $error("sample result wrong");
   // Interrupt checks skip cycles where the mask changes: irq follows it one cycle late
   irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      |(ev_r & int_en_r) && $stable(int_en_r) |-> irq)
      else $error("interrupt not raised");
   irq_low_a: assert property (@(posedge clk) disable iff (!reset_n)
      !(|(ev_r & int_en_r)) && $stable(int_en_r) |-> !irq)
      else $error("interrupt raised without enabled event");
   wake_up_a: assert property (@(posedge clk) disable iff (!reset_n)
      wake_cfg_r == LPC_WAKE_UP && fall |=> !wake_detect)
      else $error("wake on wrong direction");
   ext_ref_a: assert property (@(posedge clk) disable iff (!reset_n)
      ref_sel_r != LPC_REF_EXTERNAL |=> !analog_ctrl.external_reference)
      else $error("external reference leaked");
   no_ev_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
      !running |-> ev_set[3:1] == 3'h0)
      else $error("event while stopped");
endmodule // lpc_ctrl
`default_nettype wire

// [tb/lpc_analog_model.sv]
// Behavioural analog comparator front end that answers the control block
`timescale 1ns/1ns
`default_nettype none
module lpc_analog_model
   import lpc_pkg::*;
(
   input  wire              clk,
   input  wire lpc_analog_t analog_ctrl,
   input  wire [31:0]       pin_lvl,
   input  wire [7:0]        ext_lvl,
   output logic             comp_decision
);
   // -------------------------------------------------------------
   // Input routing, levels in sixteenths of the supply
   // -------------------------------------------------------------
   logic [4:0] vin;
   logic [4:0] vref;
   logic [2:0] psel;
   logic [2:0] rsel;

   // Split the control bundle into the selects in use
   assign psel = analog_ctrl.positive_input;
   assign rsel = analog_ctrl.reference_select;

   // Positive input from the selected pin
   assign vin = {1'b0, pin_lvl[psel * 4 +: 4]};

   // Negative input: supply eighths, or the chosen external pin
   assign vref = (rsel == LPC_REF_EXTERNAL) ?
                 {1'b0, ext_lvl[analog_ctrl.external_reference * 4 +: 4]} :
                 {1'b0, rsel, 1'b0} + 5'h02;

   // Decision is 1 when above; unpowered, the output toggles on every rising clock edge
   initial comp_decision = 1'b0;
   always @(posedge clk) begin
      if (analog_ctrl.power_on)
         comp_decision <= (vin > vref);
      else
         comp_decision <= ~comp_decision;
   end
endmodule // lpc_analog_model
`default_nettype wire

// [tb/lpc_ctrl_tb_top.sv]
// Testbench of the low power comparator control block
`timescale 1ns/1ns
`default_nettype none
module lpc_ctrl_tb_top;
   import lpc_pkg::*;
   // -------------------------------------------------------------
   // Signals and tables
   // -------------------------------------------------------------
   localparam logic [11:0] REGS [10] = '{LPC_SHORTCUT_OFS, LPC_INT_EN_OFS, LPC_INT_SET_OFS,
      LPC_INT_CLR_OFS, LPC_RESULT_OFS, LPC_ENABLE_OFS, LPC_PIN_SEL_OFS, LPC_REF_SEL_OFS,
      LPC_EXT_REF_OFS, LPC_WAKE_CFG_OFS};
   localparam logic [11:0] RW_OFS [7] = '{LPC_SHORTCUT_OFS, LPC_INT_EN_OFS, LPC_PIN_SEL_OFS,
      LPC_REF_SEL_OFS, LPC_EXT_REF_OFS, LPC_WAKE_CFG_OFS, LPC_ENABLE_OFS};
   localparam logic [31:0] RW_VAL [7] = '{32'h1A, 32'hA, 32'h5, 32'h6, 32'h1, 32'h2, 32'h1};
   logic        clk;
   logic        reset_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        comp_decision;
   lpc_analog_t analog_ctrl;
   logic        wake_detect;
   logic        irq;
   logic [31:0] pin_lvl;
   logic [7:0]  ext_lvl;
   logic [31:0] rd;
   int          n_errors;
   int          n_tests;
   int          n_wake;
   int          cycles;
   int          base;

   // Design with a short start-up count, and its analog partner
   lpc_ctrl #(.STARTUP_CYCLES(8)) u_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .comp_decision(comp_decision), .analog_ctrl(analog_ctrl),
      .wake_detect(wake_detect), .irq(irq));
   lpc_analog_model u_model (.clk(clk), .analog_ctrl(analog_ctrl), .pin_lvl(pin_lvl),
      .ext_lvl(ext_lvl), .comp_decision(comp_decision));

   // Clock, hang guard and wake pulse counter
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (wake_detect === 1'b1) n_wake++;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   // -------------------------------------------------------------
   // Bus tasks and checks
   // -------------------------------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, rd);
      chk(rd, exp, "register read");
      chk({31'h0, hresp}, 32'h0, "bus response");
   endtask
   task automatic lvl(input logic [3:0] v);
      pin_lvl[3:0] <= v;
      repeat (8) @(posedge clk);
   endtask
   task automatic sample_chk(input logic [31:0] exp);
      repeat (8) @(posedge clk);
      wr(LPC_TASK_SAMPLE_OFS, 32'h1);
      rchk(LPC_RESULT_OFS, exp);
   endtask
   task automatic clr_ev;
      for (int i = 0; i < 4; i++) wr(LPC_EV_READY_OFS + 12'(4 * i), 32'h0);
   endtask
   task automatic start_up;
      int n;
      n = 0;
      wr(LPC_EV_READY_OFS, 32'h0);
      wr(LPC_TASK_START_OFS, 32'h1);
      rchk(LPC_EV_READY_OFS, 32'h0);
      do xfer(1'b0, LPC_EV_READY_OFS, 32'h0, rd); while (rd !== 32'h1 && ++n < 50);
      chk(rd, 32'h1, "ready event");
   endtask
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {reset_n, hsel, hwrite, haddr, htrans, hwdata} = '0;
      {pin_lvl, ext_lvl} = {32'hF1F1_F1F1, 8'hC3};
      {n_errors, n_tests, n_wake, cycles} = '0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      // Reset values, unmapped place, read-only result
      foreach (REGS[i]) rchk(REGS[i], LPC_RESET_WORD);
      wr(12'h600, 32'hFFFF_FFFF);
      rchk(12'h600, 32'h0);
      foreach (RW_OFS[i]) wr(RW_OFS[i], RW_VAL[i]);
      repeat (2) @(posedge clk);
      chk({22'h0, analog_ctrl}, {22'h0, 10'b1_101_110_0_10}, "controls");
      foreach (RW_OFS[i]) rchk(RW_OFS[i], RW_VAL[i]);
      wr(LPC_RESULT_OFS, 32'h1);
      rchk(LPC_RESULT_OFS, 32'h0);
      foreach (RW_OFS[i]) wr(RW_OFS[i], 32'h0);
      // Set and clear views of the interrupt enables
      wr(LPC_INT_EN_OFS, 32'h5);
      wr(LPC_INT_SET_OFS, 32'h2);
      rchk(LPC_INT_SET_OFS, 32'h7);
      wr(LPC_INT_CLR_OFS, 32'h4);
      wr(LPC_INT_SET_OFS, 32'h0);
      wr(LPC_INT_CLR_OFS, 32'h0);
      rchk(LPC_INT_EN_OFS, 32'h3);
      wr(LPC_INT_CLR_OFS, 32'hF);
      rchk(LPC_INT_EN_OFS, 32'h0);
      // Configure selects first, then enable and start
      wr(LPC_REF_SEL_OFS, 32'h3);
      wr(LPC_ENABLE_OFS, 32'h1);
      wr(LPC_INT_SET_OFS, 32'h1);
      start_up();
      chk({31'h0, irq}, 32'h1, "irq on ready");
      wr(LPC_INT_CLR_OFS, 32'h1);
      // Pin routing and result capture
      for (int k = 0; k < 8; k++) begin
         wr(LPC_PIN_SEL_OFS, 32'(k));
         repeat (2) @(posedge clk);
         chk({29'h0, analog_ctrl.positive_input}, 32'(k), "pin select");
         sample_chk(32'(k % 2));
      end
      wr(LPC_PIN_SEL_OFS, 32'h0);
      pin_lvl[3:0] <= 4'h7;
      for (int c = 0; c < 7; c++) begin
         wr(LPC_REF_SEL_OFS, 32'(c));
         sample_chk(32'(c < 3));
      end
      wr(LPC_REF_SEL_OFS, 32'h7);
      for (int e = 0; e < 2; e++) begin
         wr(LPC_EXT_REF_OFS, 32'(e));
         sample_chk(32'(e == 0));
      end
      // Crossing events, latching and interrupt
      wr(LPC_REF_SEL_OFS, 32'h3);
      lvl(4'h1);
      clr_ev();
      wr(LPC_INT_SET_OFS, 32'h4);
      lvl(4'hF);
      chk({31'h0, irq}, 32'h1, "irq on up");
      rchk(LPC_EV_UP_OFS, 32'h1);
      rchk(LPC_EV_DOWN_OFS, 32'h0);
      wr(LPC_INT_CLR_OFS, 32'h4);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      rchk(LPC_EV_CROSS_OFS, 32'h1);
      lvl(4'h1);
      rchk(LPC_EV_DOWN_OFS, 32'h1);
      // Wake detect for each mode
      for (int c = 0; c < 3; c++) begin
         wr(LPC_WAKE_CFG_OFS, 32'(c));
         base = n_wake;
         lvl(4'hF);
         lvl(4'h1);
         chk(32'(n_wake - base), (c == 0) ? 32'h2 : 32'h1, "wake pulses");
      end
      // Shortcuts to the stop task
      clr_ev();
      wr(LPC_SHORTCUT_OFS, 32'h8);
      lvl(4'hF);
      lvl(4'h1);
      rchk(LPC_EV_DOWN_OFS, 32'h0);
      clr_ev();
      start_up();
      wr(LPC_SHORTCUT_OFS, 32'h10);
      lvl(4'hF);
      rchk(LPC_EV_CROSS_OFS, 32'h1);
      lvl(4'h1);
      rchk(LPC_EV_DOWN_OFS, 32'h0);
      wr(LPC_ENABLE_OFS, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, analog_ctrl.power_on}, 32'h0, "power off");
      end_of_test();
   end
endmodule // lpc_ctrl_tb_top
`default_nettype wire
